// *** fdi_pkg.sv ***
// fdi_pkg: constants and types of the floppy interface register port
package fdi_pkg;
  localparam int W = 12;
  // host io transfer instruction codes (low digit)
  typedef enum logic [2:0] {
    OP_NOP, OP_LOAD_CMD, OP_XFER, OP_SKIP_TR,
    OP_SKIP_ERR, OP_SKIP_DONE, OP_INT_EN, OP_INIT
  } fdi_op_t;
  // controller functions
  typedef enum logic [2:0] {
    FN_FILL, FN_EMPTY, FN_WRITE, FN_READ,
    FN_UNUSED, FN_STATUS, FN_WRITE_DEL, FN_ERR_REG
  } fdi_fn_t;
  // controller events entering the buffer
  typedef enum logic [1:0] {
    EV_DATA, EV_REQ, EV_DONE, EV_ERR
  } fdi_ev_t;
  typedef struct packed {
    fdi_ev_t        kind;
    logic [W-1:0]   word;
  } fdi_ev_word_t;
  typedef struct packed {
    fdi_fn_t func;
    logic    drive;
    logic    eight_bit;
  } fdi_cmd_t;
  // accumulator bit n sits at vector index 11-n
  localparam int FN_LSB    = 1;
  localparam int DRV_BIT   = 4;
  localparam int MODE_BIT  = 6;
  localparam int MAINT_BIT = 7;
  localparam int IE_BIT    = 0;
  localparam int ADDR_W    = 8;
  localparam int ST_CRC    = 0;
  localparam int ST_PAR    = 1;
  localparam int ST_INIT   = 2;
  localparam int ST_DD     = 6;
  localparam int ST_RDY    = 7;
  localparam int BUF_DEPTH = 2;
  localparam logic [W-1:0] ZERO_W  = 12'h000;
  localparam logic [W-1:0] LOW8_M  = 12'h0ff;
endpackage

// *** fdi_port.sv ***
// fdi_port: host interface register, flags and controller handshake
//
// Operation
// R1: one register serves six logical views
// R2: command bits 8-10 decode the function
// R3: command bit 7 selects drive
// R4: command bit 5 selects 8/12-bit words
// R5: twelve-bit mode after initialize
// R6: load command with bit 4 sets maintenance
// R7: maintenance: no run, transfers go to host
// R8: initialize or bit 4 clear ends maintenance
// R9: later maintenance loads store reliably
// R10: maintenance forces skip flags, skips keep them
// R11: flags stay set after maintenance clears
// R12: interrupt enable; interrupt on done and enable
// R13: initialize clears all flags and enable
// R14: host leaves maintenance through initialize
// R15: track address uses only low eight bits
// R16: sector address uses only low eight bits
// R17: data width fixed by command at load
// R18: status word loaded on function completion
// R19: status bit 11 reports crc failure
// R20: parity error ends function, error and done
// R21: init-done bit hidden from read status
// R22: deleted-data bit set by mark or write-deleted
// R23: no new function before previous done
// R24: done skip skips and clears done
// R25: twelve-bit register, unused bits held
module fdi_port
  import fdi_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  // host instruction side
  input  wire logic                iot_valid,
  input  wire fdi_pkg::fdi_op_t    iot_op,
  input  wire logic [fdi_pkg::W-1:0] host_ac_in,
  input  wire logic                bus_init,
  output logic [fdi_pkg::W-1:0]    host_ac_out,
  output logic                     ac_load,
  output logic                     ac_or8,
  output logic                     ac_clear,
  output logic                     skip,
  output logic                     bus_irq,
  // controller side
  input  wire logic                ctl_valid,
  input  wire fdi_pkg::fdi_ev_word_t ctl_event,
  output logic                     ctl_ready,
  input  wire logic                ctl_dir_to_host,
  input  wire logic                ctl_crc_err,
  input  wire logic                ctl_deleted_mark,
  input  wire logic                ctl_drive_ready,
  output logic                     ctl_run,
  output logic                     ctl_init,
  output fdi_pkg::fdi_cmd_t        ctl_cmd,
  output logic [fdi_pkg::W-1:0]    ctl_word,
  output logic                     maint_active
);
  import fdi_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1, rst_n;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // inputs passed in so continuous assigns re-evaluate on every change
  function automatic logic is_op(input logic en, input logic v, input fdi_op_t c, input fdi_op_t o);
    return en && v && c == o;
  endfunction

  logic [W-1:0] iface_reg, status_reg;
  logic tr_reg, err_reg, done_reg, ie_reg, maint_reg, mode_reg;
  logic wait_reg;
  fdi_fn_t fn_reg;

  logic op_lcd, op_xdr, op_init, do_init, start_fn;
  assign op_lcd   = is_op(clk_en, iot_valid, iot_op, OP_LOAD_CMD);
  assign op_xdr   = is_op(clk_en, iot_valid, iot_op, OP_XFER);
  assign op_init  = is_op(clk_en, iot_valid, iot_op, OP_INIT);
  assign do_init  = op_init || (clk_en && bus_init);
  // function only when idle and not entering test mode
  assign start_fn = op_lcd && done_reg && !maint_reg
                    && !host_ac_in[MAINT_BIT];  // [R23]
  logic xdr_out, xdr_in;
  assign xdr_out = op_xdr && (maint_reg || done_reg || ctl_dir_to_host); // [R7]
  assign xdr_in  = op_xdr && !xdr_out;

  // ----------------------------------------------------------------
  // two-entry controller buffer
  // ----------------------------------------------------------------
  // next word waits here while the host is slow, nothing is lost
  fdi_ev_word_t buf_mem [BUF_DEPTH];
  logic [1:0] buf_cnt;
  logic       buf_wp, buf_rp;
  logic       push, pop, buf_rdy;
  fdi_ev_word_t head;
  assign buf_rdy = buf_cnt != 2'(BUF_DEPTH);
  assign push = clk_en && ctl_valid && buf_rdy;
  assign pop  = clk_en && buf_cnt != 2'd0 && !wait_reg && !maint_reg && !do_init;
  assign head = buf_mem[buf_rp];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_cnt   <= 2'd0;
      buf_wp    <= 1'b0;
      buf_rp    <= 1'b0;
      ctl_ready <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        buf_mem[buf_wp] <= ctl_event;
        buf_wp          <= ~buf_wp;
      end
      if (pop)
        buf_rp <= ~buf_rp;
      buf_cnt   <= buf_cnt + 2'(push) - 2'(pop);
      ctl_ready <= (buf_cnt + 2'(push) - 2'(pop)) != 2'(BUF_DEPTH);
    end
  end

  logic ev_xfer, ev_done, ev_err;
  assign ev_xfer = pop && (head.kind == EV_DATA || head.kind == EV_REQ);
  assign ev_done = pop && head.kind == EV_DONE;
  assign ev_err  = pop && head.kind == EV_ERR;

  // ----------------------------------------------------------------
  // error and status word
  // ----------------------------------------------------------------
  logic [W-1:0] status_view;
  always_comb begin
    status_view = status_reg;
    status_view[ST_RDY] = ctl_drive_ready;
    if (fn_reg == FN_STATUS)
      status_view[ST_INIT] = 1'b0;  // [R21]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= ZERO_W;
    end else if (clk_en) begin
      if (op_init)
        status_reg <= ZERO_W;
      else if (start_fn) begin
        status_reg[ST_CRC] <= 1'b0;
        status_reg[ST_PAR] <= 1'b0;
        status_reg[ST_INIT] <= 1'b0;
      end
      if (ctl_crc_err)
        status_reg[ST_CRC] <= 1'b1;  // [R19]
      if (ev_err)
        status_reg[ST_PAR] <= 1'b1;  // [R20]
      if (ev_done && fn_reg == FN_STATUS && status_reg[ST_INIT] == 1'b0 && head.word[ST_INIT])
        status_reg[ST_INIT] <= 1'b1;  // [R21]
      if (ctl_deleted_mark || ((ev_done || ev_err) && fn_reg == FN_WRITE_DEL))
        status_reg[ST_DD] <= 1'b1;  // [R22]
    end
  end

  // ----------------------------------------------------------------
  // interface register and word mode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iface_reg <= ZERO_W;
      mode_reg  <= 1'b0;
      fn_reg    <= FN_FILL;
    end else if (clk_en) begin
      if (do_init)
        mode_reg <= 1'b0;  // [R5]
      else if (start_fn)
        mode_reg <= host_ac_in[MODE_BIT];  // [R4] [R17]
      if (op_lcd)
        iface_reg <= host_ac_in;  // [R1] [R9] [R25]
      else if (xdr_in)
        iface_reg <= host_ac_in;
      else if (ev_xfer && head.kind == EV_DATA)
        iface_reg <= head.word;
      else if (ev_done || ev_err)
        iface_reg <= status_view;  // [R18] [R20]
      if (start_fn)
        fn_reg <= fdi_fn_t'(host_ac_in[FN_LSB +: 3]);  // [R2]
    end
  end

  // ----------------------------------------------------------------
  // maintenance, flags and interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      maint_reg <= 1'b0;
    else if (clk_en) begin
      if (do_init)
        maint_reg <= 1'b0;  // [R8] [R14]
      else if (op_lcd)
        maint_reg <= host_ac_in[MAINT_BIT];  // [R6] [R8]
    end
  end

  logic sk_tr, sk_err, sk_done;
  assign sk_tr   = is_op(clk_en, iot_valid, iot_op, OP_SKIP_TR);
  assign sk_err  = is_op(clk_en, iot_valid, iot_op, OP_SKIP_ERR);
  assign sk_done = is_op(clk_en, iot_valid, iot_op, OP_SKIP_DONE);

  // controller sets win over a skip's clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tr_reg   <= 1'b0;
      err_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      if (op_init) begin
        tr_reg   <= 1'b0;  // [R13]
        err_reg  <= 1'b0;
        done_reg <= 1'b0;
      end else if (maint_reg) begin
        tr_reg   <= 1'b1;  // [R10] [R11]
        err_reg  <= 1'b1;
        done_reg <= 1'b1;
      end else begin
        if (ev_xfer)
          tr_reg <= 1'b1;
        else if (sk_tr)
          tr_reg <= 1'b0;
        if (ev_err)
          err_reg <= 1'b1;
        else if (sk_err)
          err_reg <= 1'b0;
        if (ev_done || ev_err)
          done_reg <= 1'b1;
        else if (sk_done || start_fn)
          done_reg <= 1'b0;  // [R24]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      ie_reg <= 1'b0;
    else if (clk_en) begin
      if (op_init)
        ie_reg <= 1'b0;  // [R13]
      else if (is_op(clk_en, iot_valid, iot_op, OP_INT_EN))
        ie_reg <= host_ac_in[IE_BIT];  // [R12]
    end
  end

  // host must service each transfer before the next event drains
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      wait_reg <= 1'b0;
    else if (clk_en) begin
      if (do_init)
        wait_reg <= 1'b0;
      else if (ev_xfer)
        wait_reg <= 1'b1;
      else if (op_xdr && !maint_reg)
        wait_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  function automatic logic [W-1:0] merge8(input logic [W-1:0] ac, input logic [W-1:0] w);
    return (ac & ~LOW8_M) | (ac & LOW8_M) | (w & LOW8_M);
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_ac_out <= ZERO_W;
      ac_load     <= 1'b0;
      ac_clear    <= 1'b0;
      ac_or8      <= 1'b0;
      skip        <= 1'b0;
      bus_irq     <= 1'b0;
    end else if (clk_en) begin
      ac_load  <= xdr_out;  // [R7]
      ac_clear <= op_lcd;
      ac_or8   <= mode_reg;
      if (xdr_out)
        host_ac_out <= mode_reg ? merge8(host_ac_in, iface_reg) : iface_reg;
      skip <= (sk_tr && tr_reg) || (sk_err && err_reg)
              || (sk_done && done_reg);  // [R24]
      bus_irq <= done_reg && ie_reg;  // [R12]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_run      <= 1'b0;
      ctl_init     <= 1'b0;
      ctl_cmd      <= '0;
      ctl_word     <= ZERO_W;
      maint_active <= 1'b0;
    end else if (clk_en) begin
      ctl_init     <= do_init;
      maint_active <= maint_reg;
      ctl_run      <= start_fn || (op_xdr && !maint_reg && !done_reg);  // [R7]
      if (start_fn) begin
        ctl_cmd.func      <= fdi_fn_t'(host_ac_in[FN_LSB +: 3]);  // [R2]
        ctl_cmd.drive     <= host_ac_in[DRV_BIT];  // [R3]
        ctl_cmd.eight_bit <= host_ac_in[MODE_BIT];  // [R4]
      end
      // address words and 8-bit data only use the low byte
      if (xdr_in)
        ctl_word <= (mode_reg || !ctl_dir_to_host && fn_reg != FN_FILL)
                    ? (host_ac_in & LOW8_M) : host_ac_in;  // [R15] [R16] [R17]
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  maint_set_a: assert property (clk_en && op_lcd && host_ac_in[MAINT_BIT] && !do_init
    |=> maint_reg) else $error("maintenance not set");  // [R6]
  maint_clr_a: assert property (do_init |=> !maint_reg)
    else $error("maintenance survived init");  // [R8]
  maint_norun_a: assert property (maint_reg && op_xdr |=> !ctl_run && ac_load)
    else $error("run during maintenance");  // [R7]
  maint_flags_a: assert property (maint_reg && !op_init |=> tr_reg && err_reg && done_reg)
    else $error("flags not forced");  // [R10]
  init_clear_a: assert property (op_init |=> !tr_reg && !err_reg && !done_reg && !ie_reg)
    else $error("init left flags");  // [R13]
  irq_cause_a: assert property (clk_en ##1 clk_en |-> bus_irq == $past(done_reg && ie_reg))
    else $error("irq mismatch");  // [R12]
  done_skip_a: assert property (sk_done && done_reg && !maint_reg && !ev_done && !ev_err
    |=> skip && !done_reg) else $error("done skip wrong");  // [R24]
  busy_refuse_a: assert property (op_lcd && !done_reg |=> !ctl_run)
    else $error("function started while busy");  // [R23]
  mode_init_a: assert property (do_init |=> !mode_reg)
    else $error("mode not 12-bit");  // [R5]
  stat_load_a: assert property (ev_done && !op_lcd && !op_xdr |=> iface_reg[ST_RDY] == $past(ctl_drive_ready))
    else $error("status not loaded");  // [R18]
  cmd_drive_a: assert property (start_fn |=> ctl_cmd.drive == $past(host_ac_in[DRV_BIT]))
    else $error("drive select wrong");  // [R3]

  cov_maint_c: cover property (op_lcd && host_ac_in[MAINT_BIT] ##[1:8] ac_load);
  cov_fill_c: cover property (start_fn ##[1:20] ev_done);
  cov_irq_c: cover property (ie_reg && done_reg ##1 bus_irq);
  cov_full_c: cover property (buf_cnt == 2'(BUF_DEPTH));
endmodule

// *** fdi_ctl_model.sv ***
// fdi_ctl_model: behavioural disk controller feeding the event stream
module fdi_ctl_model (
  // clock
  input  wire logic           ref_clk,
  // event stream
  input  wire logic           ctl_ready,
  output logic                ctl_valid,
  output fdi_pkg::fdi_ev_word_t ctl_event
);
  import fdi_pkg::*;
  initial begin
    ctl_valid = 1'b0;
    ctl_event = '0;
  end
  // ----------------------------------------
  // one event, held until an edge sees ready
  // ----------------------------------------
  task automatic push(input fdi_ev_t k, input logic [W-1:0] w);
    @(negedge ref_clk);
    ctl_valid = 1'b1;
    ctl_event = '{kind: k, word: w};
    @(posedge ref_clk);
    while (ctl_ready !== 1'b1) @(posedge ref_clk);
    @(negedge ref_clk);
    ctl_valid = 1'b0;
    // released line shows the inverse, not a stale word
    ctl_event.word = ~w;
  endtask
endmodule

// *** fdi_port_tb_top.sv ***
// fdi_port_tb_top: self-checking bench for the interface register port
module fdi_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fdi_pkg::*;
  logic ref_clk, reset_n, clk_en, iot_valid, bus_init;
  fdi_op_t iot_op;
  logic [W-1:0] host_ac_in, host_ac_out, ctl_word, a;
  logic [W-1:0] w [4];
  logic ac_load, ac_or8, ac_clear, skip, bus_irq, ctl_valid, ctl_ready;
  logic ctl_dir_to_host, ctl_crc_err, ctl_deleted_mark, ctl_drive_ready;
  logic ctl_run, ctl_init, maint_active;
  fdi_ev_word_t ctl_event;
  fdi_cmd_t ctl_cmd;
  logic [W-1:0] exp_q [$];
  logic [15:0] xs_state = 16'h005e;
  int err_count = 0;
  int samples_checked = 0;
  fdi_port fdi_port_inst (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .iot_valid(iot_valid), .iot_op(iot_op), .host_ac_in(host_ac_in), .bus_init(bus_init),
    .host_ac_out(host_ac_out), .ac_load(ac_load), .ac_or8(ac_or8), .ac_clear(ac_clear),
    .skip(skip), .bus_irq(bus_irq), .ctl_valid(ctl_valid), .ctl_event(ctl_event),
    .ctl_ready(ctl_ready), .ctl_dir_to_host(ctl_dir_to_host), .ctl_crc_err(ctl_crc_err),
    .ctl_deleted_mark(ctl_deleted_mark), .ctl_drive_ready(ctl_drive_ready),
    .ctl_run(ctl_run), .ctl_init(ctl_init), .ctl_cmd(ctl_cmd), .ctl_word(ctl_word),
    .maint_active(maint_active));
  fdi_ctl_model fdi_ctl_model_inst (.ref_clk(ref_clk), .ctl_ready(ctl_ready),
    .ctl_valid(ctl_valid), .ctl_event(ctl_event));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [W-1:0] xs();
    xs_state ^= xs_state << 7;
    xs_state ^= xs_state >> 9;
    xs_state ^= xs_state << 8;
    return xs_state[W-1:0];
  endfunction
  task automatic chk(input string n, input logic [W-1:0] seen, input logic [W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // answer pulses are sampled on the falling edge after the take
  task automatic ins(input fdi_op_t op, input logic [W-1:0] ac);
    @(negedge ref_clk);
    iot_valid = 1'b1;
    iot_op = op;
    host_ac_in = ac;
    @(negedge ref_clk);
    iot_valid = 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic ev(input fdi_ev_t k, input logic [W-1:0] v);
    fdi_ctl_model_inst.push(k, v);
    settle();
  endtask
  // ----------------------------------------
  // watcher: every accumulator load against the oldest note
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (ac_load === 1'b1) begin
      if (exp_q.size() == 0) chk("stray ac_load", 12'h001, 12'h000);
      else chk("host_ac_out", host_ac_out, exp_q.pop_front());
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #2000000;
    err_count++;
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n, iot_valid, bus_init, ctl_dir_to_host, ctl_crc_err, ctl_deleted_mark} = '0;
    clk_en = 1'b1;
    ctl_drive_ready = 1'b1;
    iot_op = OP_NOP;
    host_ac_in = 12'h000;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    settle();
    chk("maint reset", maint_active, 1'b0);
    chk("ac_or8 reset", ac_or8, 1'b0);
    for (int i = 0; i < 8; i++) begin
      ev(EV_DONE, xs());
      a = xs();
      a[MAINT_BIT] = 1'b0;
      a[FN_LSB+:3] = i[2:0];
      ins(OP_LOAD_CMD, a);
      chk("ac_clear", ac_clear, 1'b1);
      chk("ctl_run", ctl_run, 1'b1);
      chk("func", ctl_cmd.func, a[FN_LSB+:3]);
      chk("drive", ctl_cmd.drive, a[DRV_BIT]);
      chk("eight_bit", ctl_cmd.eight_bit, a[MODE_BIT]);
      @(negedge ref_clk);
      chk("ac_or8", ac_or8, a[MODE_BIT]);
      ins(OP_LOAD_CMD, a);
      chk("refused run", ctl_run, 1'b0);
    end
    ins(OP_INIT, 12'h000);
    chk("ctl_init", ctl_init, 1'b1);
    @(negedge ref_clk);
    chk("ac_or8 init", ac_or8, 1'b0);
    // full buffer with the host slow, then a stalled fourth word
    ctl_dir_to_host = 1'b1;
    for (int i = 0; i < 3; i++) begin
      w[i] = xs();
      fdi_ctl_model_inst.push(EV_DATA, w[i]);
    end
    settle();
    chk("ctl_ready full", ctl_ready, 1'b0);
    w[3] = xs();
    fork
      fdi_ctl_model_inst.push(EV_DATA, w[3]);
      for (int i = 0; i < 4; i++) begin
        settle();
        ins(OP_SKIP_TR, 12'h000);
        chk("skip tr", skip, 1'b1);
        exp_q.push_back(w[i]);
        ins(OP_XFER, 12'h000);
      end
    join
    ctl_dir_to_host = 1'b0;
    ctl_crc_err = 1'b1;
    ctl_deleted_mark = 1'b1;
    @(negedge ref_clk);
    {ctl_crc_err, ctl_deleted_mark} = 2'b00;
    ev(EV_DONE, 12'h000);
    ins(OP_LOAD_CMD, {8'h00, FN_WRITE, 1'b0});
    ev(EV_REQ, 12'h000);
    ins(OP_SKIP_TR, 12'h000);
    chk("skip req", skip, 1'b1);
    ins(OP_XFER, 12'hfff);
    chk("xfer run", ctl_run, 1'b1);
    chk("ctl_word", ctl_word, 12'h0ff);
    ev(EV_ERR, 12'h000);
    ins(OP_SKIP_ERR, 12'h000);
    chk("skip err", skip, 1'b1);
    ins(OP_SKIP_DONE, 12'h000);
    chk("skip done", skip, 1'b1);
    ins(OP_SKIP_DONE, 12'h000);
    chk("done cleared", skip, 1'b0);
    // maintenance loopback and forced flags
    ins(OP_LOAD_CMD, 12'h080);
    @(negedge ref_clk);
    chk("maint set", maint_active, 1'b1);
    a = xs() | 12'h080;
    a[MODE_BIT] = 1'b0;
    ins(OP_LOAD_CMD, a);
    exp_q.push_back(a);
    ins(OP_XFER, 12'h000);
    chk("maint run", ctl_run, 1'b0);
    for (int i = 0; i < 2; i++) begin
      ins(OP_SKIP_TR, 12'h000);
      chk("forced skip", skip, 1'b1);
    end
    ins(OP_INT_EN, 12'h001);
    @(negedge ref_clk);
    chk("bus_irq", bus_irq, 1'b1);
    ins(OP_LOAD_CMD, 12'h000);
    @(negedge ref_clk);
    chk("maint off", maint_active, 1'b0);
    ins(OP_SKIP_ERR, 12'h000);
    chk("kept flag", skip, 1'b1);
    ins(OP_SKIP_ERR, 12'h000);
    chk("flag spent", skip, 1'b0);
    ins(OP_INIT, 12'h000);
    @(negedge ref_clk);
    chk("irq init", bus_irq, 1'b0);
    ins(OP_SKIP_TR, 12'h000);
    chk("flags init", skip, 1'b0);
    ins(OP_LOAD_CMD, 12'h080);
    bus_init = 1'b1;
    @(negedge ref_clk);
    bus_init = 1'b0;
    settle();
    chk("bus init maint", maint_active, 1'b0);
    chk("queue drained", 12'(exp_q.size()), 12'h000);
    test_done();
  end
endmodule
